// [common/smbus_cfg_pkg.sv]
// constants, types and helpers shared by both ends of the management link
// How it works
// - link and registers live only while enable high; register outputs stay driven while low
// - all address pins low answers at 1010000
// - address pins fill address byte bits 4:1
// - data line stable while clock line high
// - data falling while clock high starts message
// - data rising while clock high stops message
// - idle after free time or long high
// - write: address, index, data, each acknowledged low
// - read: index write, restart, byte, host nack
// - 01 to register 00 restores defaults
// - host programs every swing register before use
// - b-side equalization registers at 0F,16,1D,24
// - eight de-emphasis registers, one per output
// - host writes only five legal de-emphasis codes
// - 4E bit 0 turns address pins into outputs
// - 47[5:4], 4C[7:6] enable OR-ed status blocks
// - idle status on paired channel pins
// - idle pin high means no signal
// - board floats rate and idle pins
// - rate status on pairs, high means fast
`default_nettype none
package smbus_cfg_pkg;
  localparam int CLK_MHZ = 100;
  localparam int T_BUF_NS = 4700;
  localparam int T_HIGH_MAX_NS = 50000;
  localparam int SCL_PERIOD_NS = 10000;
  localparam int T_BUF_CYC = (T_BUF_NS * CLK_MHZ + 999) / 1000;
  localparam int T_HIGH_MAX_CYC = T_HIGH_MAX_NS * CLK_MHZ / 1000;
  localparam int SCL_QUARTER_CYC = SCL_PERIOD_NS * CLK_MHZ / 4000;
  localparam int REG_COUNT = 128;
  localparam logic [2:0] ADDR_FIXED = 3'h5;
  localparam logic [3:0] ADDR_PINS_OFF = 4'h0;
  localparam logic [7:0] REG_SOFT_RESET = 8'h00;
  localparam logic [7:0] REG_IDLE_ROUTE = 8'h47;
  localparam logic [7:0] REG_RATE_ROUTE = 8'h4C;
  localparam logic [7:0] REG_PIN_CFG = 8'h4E;
  localparam logic [3:0][7:0] EQ_OFS = {8'h24, 8'h1D, 8'h16, 8'h0F};
  localparam logic [7:0][7:0] SWING_OFS = {8'h42, 8'h3B, 8'h34, 8'h2D, 8'h25, 8'h1E, 8'h17, 8'h10};
  localparam logic [7:0][7:0] DEEMPH_OFS = {8'h43, 8'h3C, 8'h35, 8'h2E, 8'h26, 8'h1F, 8'h18, 8'h11};
  localparam logic [4:0][7:0] DEEMPH_CODES = {8'hA0, 8'h90, 8'h88, 8'hE8, 8'h01};
  localparam logic [7:0] EQ_DEFAULT = 8'h20;
  localparam logic [7:0] SWING_DEFAULT = 8'h03;
  localparam logic [7:0] OTHER_DEFAULT = 8'h00;
  localparam int SOFT_RESET_BIT = 0;
  localparam int GPIO_MODE_BIT = 0;
  localparam int IDLE_EN_LO = 4;
  localparam int IDLE_EN_HI = 5;
  localparam int RATE_EN_LO = 6;
  localparam int RATE_EN_HI = 7;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [2:0] STEP_START = 3'h0;
  localparam logic [2:0] STEP_ADDR = 3'h1;
  localparam logic [2:0] STEP_INDEX = 3'h2;
  localparam logic [2:0] STEP_WDATA = 3'h3;
  localparam logic [2:0] STEP_W_STOP = 3'h4;
  localparam logic [2:0] STEP_RESTART = 3'h3;
  localparam logic [2:0] STEP_RADDR = 3'h4;
  localparam logic [2:0] STEP_RDATA = 3'h5;
  localparam logic [2:0] STEP_R_STOP = 3'h6;
  localparam logic [2:0] PH_SETUP = 3'h0;
  localparam logic [2:0] PH_RISE = 3'h1;
  localparam logic [2:0] PH_HIGH = 3'h2;
  localparam logic [2:0] PH_FALL = 3'h3;
  localparam logic [2:0] PH_LAST = 3'h5;

  typedef enum logic [3:0] {
    D_IDLE = 4'h0, D_ADDR = 4'h1, D_ADDR_ACK = 4'h3, D_INDEX = 4'h2, D_INDEX_ACK = 4'h6,
    D_WDATA = 4'h7, D_WDATA_ACK = 4'h5, D_RDATA = 4'h4, D_RACK = 4'hC, D_IGNORE = 4'h8
  } dev_state_e;

  typedef enum logic [1:0] {
    H_IDLE = 2'h0, H_START = 2'h1, H_BIT = 2'h3, H_STOP = 2'h2
  } host_state_e;

  // power-on and soft-reset contents of the register file
  function automatic logic [REG_COUNT-1:0][7:0] mem_defaults();
    logic [REG_COUNT-1:0][7:0] m;
    m = '{default: OTHER_DEFAULT};
    for (int i = 0; i < 4; i++) begin
      m[EQ_OFS[i][6:0]] = EQ_DEFAULT;
    end
    for (int i = 0; i < 8; i++) begin
      m[SWING_OFS[i][6:0]] = SWING_DEFAULT;
    end
    return m;
  endfunction
endpackage
`default_nettype wire

// [common/smbus_link_if.sv]
// open-drain two-wire management link between host and device
`timescale 1ns/1ns
`default_nettype none
interface smbus_link_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic scl;
  logic sda;

  // pull-ups win unless a driver pulls low
  assign scl = host_scl_oe ? host_scl_o : 1'b1;
  assign sda = (host_sda_oe ? host_sda_o : 1'b1) & (dev_sda_oe ? dev_sda_o : 1'b1);

  modport device (input scl, input sda, output dev_sda_o, output dev_sda_oe);
  modport host (input scl, input sda, output host_scl_o, output host_scl_oe, output host_sda_o, output host_sda_oe);
endinterface
`default_nettype wire

// [rtl/smbus_cfg_host.sv]
// management link master: one register write or read per request
`timescale 1ns/1ns
`default_nettype none
module smbus_cfg_host #(
  parameter int QUARTER_CYC = smbus_cfg_pkg::SCL_QUARTER_CYC
) (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  smbus_link_if.host bus,
  input wire logic req_in,
  input wire logic rw_in,
  input wire logic [6:0] dev_addr_in,
  input wire logic [7:0] index_in,
  input wire logic [7:0] wdata_in,
  output logic busy_out,
  output logic done_out,
  output logic nack_out,
  output logic refused_out,
  output logic [7:0] rdata_out,
  output logic swing_set_out
);
  typedef struct packed {
    logic [2:0] sync;
    logic sda;
    smbus_cfg_pkg::host_state_e st;
    logic [2:0] ph;
    logic [15:0] qc;
    logic [2:0] step;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic [8:0] rx;
    logic rw;
    logic [6:0] addr;
    logic [7:0] idx;
    logic [7:0] wd;
    logic scl_oe;
    logic sda_oe;
    logic done;
    logic nack;
    logic refused;
    logic [7:0] rdata;
    logic [7:0] swing_ok;
  } host_s;

  host_s r;
  host_s n;
  logic tick;
  logic illegal;
  logic [7:0] byte_v;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    n = r;
    n.sync = {r.sync[1:0], bus.sda};
    if (r.sync[1] == r.sync[2]) begin
      n.sda = r.sync[2];
    end
    n.done = 1'b0;
    n.refused = 1'b0;
    tick = (r.qc == 16'(QUARTER_CYC - 1));
    n.qc = (r.st == smbus_cfg_pkg::H_IDLE || tick) ? 16'h0000 : r.qc + 16'h0001;
    illegal = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (index_in == smbus_cfg_pkg::DEEMPH_OFS[i]) begin
        illegal = 1'b1;
      end
    end
    for (int i = 0; i < 5; i++) begin
      if (wdata_in == smbus_cfg_pkg::DEEMPH_CODES[i]) begin
        illegal = 1'b0;
      end
    end
    // byte that follows the one just ended; read data bits stay released
    case (r.step)
      smbus_cfg_pkg::STEP_ADDR: byte_v = r.idx;
      smbus_cfg_pkg::STEP_INDEX: byte_v = r.wd;
      default: byte_v = 8'hFF;
    endcase
    case (r.st)
      smbus_cfg_pkg::H_IDLE: begin
        if (req_in && !rw_in && illegal) begin
          n.refused = 1'b1;
          n.done = 1'b1;
        end else if (req_in) begin
          n.rw = rw_in;
          n.addr = dev_addr_in;
          n.idx = index_in;
          n.wd = wdata_in;
          n.nack = 1'b0;
          n.step = smbus_cfg_pkg::STEP_START;
          n.ph = smbus_cfg_pkg::PH_SETUP;
          n.st = smbus_cfg_pkg::H_START;
        end
      end
      smbus_cfg_pkg::H_START: begin
        if (tick) begin
          n.ph = r.ph + 3'h1;
          case (r.ph)
            smbus_cfg_pkg::PH_SETUP: begin
              n.scl_oe = 1'b1;
              n.sda_oe = 1'b0;
            end
            smbus_cfg_pkg::PH_RISE: n.scl_oe = 1'b0;
            smbus_cfg_pkg::PH_HIGH: n.sda_oe = 1'b1;
            default: begin
              n.scl_oe = 1'b1;
              n.step = r.step + 3'h1;
              n.st = smbus_cfg_pkg::H_BIT;
              n.ph = smbus_cfg_pkg::PH_SETUP;
              n.bitn = 4'h0;
            end
          endcase
        end
        if (n.st == smbus_cfg_pkg::H_BIT) begin
          n.sh = (r.step == smbus_cfg_pkg::STEP_RESTART) ? {r.addr, 1'b1} : {r.addr, 1'b0};
        end
      end
      smbus_cfg_pkg::H_BIT: begin
        if (tick) begin
          n.ph = r.ph + 3'h1;
          case (r.ph)
            smbus_cfg_pkg::PH_SETUP: n.sda_oe = (r.bitn == smbus_cfg_pkg::BYTE_BITS) ? 1'b0 : ~r.sh[7];
            smbus_cfg_pkg::PH_RISE: n.scl_oe = 1'b0;
            smbus_cfg_pkg::PH_HIGH: n.rx = {r.rx[7:0], r.sda};
            default: begin
              n.scl_oe = 1'b1;
              n.ph = smbus_cfg_pkg::PH_SETUP;
              n.sh = {r.sh[6:0], 1'b1};
              n.bitn = r.bitn + 4'h1;
              if (r.bitn == smbus_cfg_pkg::BYTE_BITS) begin
                n.bitn = 4'h0;
                n.step = r.step + 3'h1;
                if (r.rw && r.step == smbus_cfg_pkg::STEP_RDATA) begin
                  n.rdata = r.rx[8:1];
                end else if (r.rx[0]) begin
                  n.nack = 1'b1;
                  n.step = r.rw ? smbus_cfg_pkg::STEP_R_STOP : smbus_cfg_pkg::STEP_W_STOP;
                end
                if (n.step == (r.rw ? smbus_cfg_pkg::STEP_R_STOP : smbus_cfg_pkg::STEP_W_STOP)) begin
                  n.st = smbus_cfg_pkg::H_STOP;
                end else if (r.rw && n.step == smbus_cfg_pkg::STEP_RESTART) begin
                  n.st = smbus_cfg_pkg::H_START;
                end
              end
            end
          endcase
        end
        if (tick && r.ph == smbus_cfg_pkg::PH_FALL && r.bitn == smbus_cfg_pkg::BYTE_BITS) begin
          n.sh = byte_v;
        end
      end
      smbus_cfg_pkg::H_STOP: begin
        if (tick) begin
          n.ph = r.ph + 3'h1;
          case (r.ph)
            smbus_cfg_pkg::PH_SETUP: begin
              n.scl_oe = 1'b1;
              n.sda_oe = 1'b1;
            end
            smbus_cfg_pkg::PH_RISE: n.scl_oe = 1'b0;
            smbus_cfg_pkg::PH_HIGH: n.sda_oe = 1'b0;
            smbus_cfg_pkg::PH_LAST: begin
              n.st = smbus_cfg_pkg::H_IDLE;
              n.done = 1'b1;
              if (!r.rw && !r.nack) begin
                for (int i = 0; i < 8; i++) begin
                  if (r.idx == smbus_cfg_pkg::SWING_OFS[i]) begin
                    n.swing_ok[i] = 1'b1;
                  end
                end
                if (r.idx == smbus_cfg_pkg::REG_SOFT_RESET && r.wd[smbus_cfg_pkg::SOFT_RESET_BIT]) begin
                  n.swing_ok = 8'h00;
                end
              end
            end
            default: n.ph = r.ph + 3'h1;
          endcase
        end
      end
      default: n.st = smbus_cfg_pkg::H_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      r <= '0;
      r.sync <= 3'h7;
      r.sda <= 1'b1;
      r.st <= smbus_cfg_pkg::H_IDLE;
    end else begin
      r <= n;
    end
  end

  assign bus.host_scl_o = 1'b0;
  assign bus.host_scl_oe = r.scl_oe;
  assign bus.host_sda_o = 1'b0;
  assign bus.host_sda_oe = r.sda_oe;
  assign busy_out = (r.st != smbus_cfg_pkg::H_IDLE);
  assign done_out = r.done;
  assign nack_out = r.nack;
  assign refused_out = r.refused;
  assign rdata_out = r.rdata;
  assign swing_set_out = &r.swing_ok;
endmodule
`default_nettype wire

// [rtl/smbus_cfg_slave.sv]
// management link slave with configuration registers and status pin routing
`timescale 1ns/1ns
`default_nettype none
module smbus_cfg_slave #(
  parameter int HIGH_MAX_CYC = smbus_cfg_pkg::T_HIGH_MAX_CYC
) (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  smbus_link_if.device bus,
  input wire logic smbus_mode_enable_in,
  input wire logic [3:0] gpio_in,
  output logic [3:0] gpio_out,
  output logic [3:0] gpio_oe_out,
  input wire logic [7:0] idle_det_in,
  input wire logic [7:0] rate_det_in,
  output logic [3:0][7:0] eq_out,
  output logic [7:0][7:0] swing_out,
  output logic [7:0][7:0] deemph_out,
  output logic bus_idle_out
);
  typedef struct packed {
    logic [7:0] rate;
    logic [7:0] idle;
    logic en;
    logic [3:0] ad;
    logic scl;
    logic sda;
  } pins_s;

  typedef struct packed {
    pins_s s1;
    pins_s s2;
    pins_s s3;
    pins_s flt;
    logic scl_q;
    logic sda_q;
    smbus_cfg_pkg::dev_state_e st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] idx;
    logic rd;
    logic stop_seen;
    logic idle;
    logic [15:0] free;
    logic sda_oe;
    logic gpio_en;
    logic [3:0] gpio;
    logic [smbus_cfg_pkg::REG_COUNT-1:0][7:0] mem;
  } dev_s;

  localparam pins_s PINS_RST = '{rate: 8'h00, idle: 8'h00, en: 1'b0, ad: 4'h0, scl: 1'b1, sda: 1'b1};

  dev_s r;
  dev_s n;
  pins_s raw;
  pins_s diff;
  logic rise;
  logic fall;
  logic start;
  logic stop;
  logic timeout;
  logic [6:0] my_addr;
  logic [7:0] rd_byte;
  logic [7:0] idle_rt;
  logic [7:0] rate_rt;
  int lo;

  function automatic logic [7:0] fetch(input logic [smbus_cfg_pkg::REG_COUNT-1:0][7:0] m, input logic [7:0] a);
    fetch = a[7] ? 8'h00 : m[a[6:0]];
  endfunction

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    n = r;
    lo = 0;
    raw = '{rate: rate_det_in, idle: idle_det_in, en: smbus_mode_enable_in, ad: gpio_in, scl: bus.scl, sda: bus.sda};
    n.s1 = raw;
    n.s2 = r.s1;
    n.s3 = r.s2;
    diff = r.s2 ^ r.s3;
    n.flt = (r.s2 & ~diff) | (r.flt & diff);
    n.scl_q = r.flt.scl;
    n.sda_q = r.flt.sda;
    rise = r.flt.scl & ~r.scl_q;
    fall = ~r.flt.scl & r.scl_q;
    start = r.flt.scl & r.scl_q & r.sda_q & ~r.flt.sda;
    stop = r.flt.scl & r.scl_q & ~r.sda_q & r.flt.sda;

    // bus free / clock high watchdog
    if (r.flt.scl && r.flt.sda) begin
      n.free = (r.free == 16'hFFFF) ? r.free : r.free + 16'h0001;
    end else begin
      n.free = 16'h0000;
    end
    if (start) begin
      n.stop_seen = 1'b0;
    end else if (stop) begin
      n.stop_seen = 1'b1;
    end
    timeout = (r.free >= 16'(HIGH_MAX_CYC));
    n.idle = (r.stop_seen && r.free >= 16'(smbus_cfg_pkg::T_BUF_CYC)) || timeout;

    // status pins
    n.gpio_en = r.flt.en && r.mem[smbus_cfg_pkg::REG_PIN_CFG[6:0]][smbus_cfg_pkg::GPIO_MODE_BIT];
    idle_rt = r.mem[smbus_cfg_pkg::REG_IDLE_ROUTE[6:0]];
    rate_rt = r.mem[smbus_cfg_pkg::REG_RATE_ROUTE[6:0]];
    for (int k = 0; k < 4; k++) begin
      lo = k + (k & 2);
      n.gpio[k] = (idle_rt[smbus_cfg_pkg::IDLE_EN_LO] & r.flt.idle[lo])
                | (idle_rt[smbus_cfg_pkg::IDLE_EN_HI] & r.flt.idle[lo + 2])
                | (rate_rt[smbus_cfg_pkg::RATE_EN_LO] & r.flt.rate[lo])
                | (rate_rt[smbus_cfg_pkg::RATE_EN_HI] & r.flt.rate[lo + 2]);
    end

    my_addr = {smbus_cfg_pkg::ADDR_FIXED, r.gpio_en ? smbus_cfg_pkg::ADDR_PINS_OFF : r.flt.ad};
    rd_byte = fetch(r.mem, r.idx);

    ////////////////////////////////////////////////////////////////////////
    // transaction engine: sample on clock rise, change the data line on clock fall
    if (!r.flt.en) begin
      n.st = smbus_cfg_pkg::D_IDLE;
      n.sda_oe = 1'b0;
    end else if (start) begin
      n.st = smbus_cfg_pkg::D_ADDR;
      n.cnt = 4'h0;
      n.sda_oe = 1'b0;
    end else if (stop || timeout) begin
      n.st = smbus_cfg_pkg::D_IDLE;
      n.sda_oe = 1'b0;
    end else begin
      case (r.st)
        smbus_cfg_pkg::D_ADDR, smbus_cfg_pkg::D_INDEX, smbus_cfg_pkg::D_WDATA: begin
          if (rise) begin
            n.sh = {r.sh[6:0], r.flt.sda};
            n.cnt = r.cnt + 4'h1;
          end
          if (fall && r.cnt == smbus_cfg_pkg::BYTE_BITS) begin
            n.cnt = 4'h0;
            n.sda_oe = 1'b1;
            case (r.st)
              smbus_cfg_pkg::D_ADDR: begin
                n.rd = r.sh[0];
                n.st = smbus_cfg_pkg::D_ADDR_ACK;
                if (r.sh[7:1] != my_addr) begin
                  n.sda_oe = 1'b0;
                  n.st = smbus_cfg_pkg::D_IGNORE;
                end
              end
              smbus_cfg_pkg::D_INDEX: begin
                n.idx = r.sh;
                n.st = smbus_cfg_pkg::D_INDEX_ACK;
              end
              default: begin
                n.st = smbus_cfg_pkg::D_WDATA_ACK;
                if (!r.idx[7]) begin
                  n.mem[r.idx[6:0]] = r.sh;
                end
                if (r.idx == smbus_cfg_pkg::REG_SOFT_RESET && r.sh[smbus_cfg_pkg::SOFT_RESET_BIT]) begin
                  n.mem = smbus_cfg_pkg::mem_defaults();
                end
              end
            endcase
          end
        end
        smbus_cfg_pkg::D_ADDR_ACK: begin
          if (fall) begin
            if (r.rd) begin
              n.sh = rd_byte;
              n.sda_oe = ~rd_byte[7];
              n.cnt = 4'h1;
              n.st = smbus_cfg_pkg::D_RDATA;
            end else begin
              n.sda_oe = 1'b0;
              n.st = smbus_cfg_pkg::D_INDEX;
            end
          end
        end
        smbus_cfg_pkg::D_INDEX_ACK: begin
          if (fall) begin
            n.sda_oe = 1'b0;
            n.st = smbus_cfg_pkg::D_WDATA;
          end
        end
        smbus_cfg_pkg::D_WDATA_ACK: begin
          if (fall) begin
            n.sda_oe = 1'b0;
            n.idx = r.idx + 8'h01;
            n.st = smbus_cfg_pkg::D_WDATA;
          end
        end
        smbus_cfg_pkg::D_RDATA: begin
          if (fall) begin
            if (r.cnt == smbus_cfg_pkg::BYTE_BITS) begin
              n.sda_oe = 1'b0;
              n.st = smbus_cfg_pkg::D_RACK;
            end else begin
              n.sh = {r.sh[6:0], 1'b0};
              n.sda_oe = ~r.sh[6];
              n.cnt = r.cnt + 4'h1;
            end
          end
        end
        smbus_cfg_pkg::D_RACK: begin
          if (rise) begin
            n.rd = ~r.flt.sda;
          end
          if (fall) begin
            if (r.rd) begin
              n.idx = r.idx + 8'h01;
              n.sh = fetch(r.mem, r.idx + 8'h01);
              n.sda_oe = ~n.sh[7];
              n.cnt = 4'h1;
              n.st = smbus_cfg_pkg::D_RDATA;
            end else begin
              n.st = smbus_cfg_pkg::D_IGNORE;
            end
          end
        end
        smbus_cfg_pkg::D_IGNORE: n.sda_oe = 1'b0;
        smbus_cfg_pkg::D_IDLE: n.sda_oe = 1'b0;
        default: begin
          n.st = smbus_cfg_pkg::D_IDLE;
          n.sda_oe = 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      r <= '0;
      r.s1 <= PINS_RST;
      r.s2 <= PINS_RST;
      r.s3 <= PINS_RST;
      r.flt <= PINS_RST;
      r.scl_q <= 1'b1;
      r.sda_q <= 1'b1;
      r.st <= smbus_cfg_pkg::D_IDLE;
      r.mem <= smbus_cfg_pkg::mem_defaults();
    end else begin
      r <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign bus.dev_sda_o = 1'b0;
  assign bus.dev_sda_oe = r.sda_oe;
  assign gpio_out = r.gpio;
  assign gpio_oe_out = {4{r.gpio_en}};
  assign bus_idle_out = r.idle;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      eq_out[i] = r.mem[smbus_cfg_pkg::EQ_OFS[i][6:0]];
    end
    for (int i = 0; i < 8; i++) begin
      swing_out[i] = r.mem[smbus_cfg_pkg::SWING_OFS[i][6:0]];
      deemph_out[i] = r.mem[smbus_cfg_pkg::DEEMPH_OFS[i][6:0]];
    end
  end
endmodule
`default_nettype wire

// [dv/smbus_link_monitor.sv]
// concurrent checks on the shared management link wires
`timescale 1ns/1ns
`default_nettype none
module smbus_link_monitor (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic host_sda_oe_in,
  input wire logic dev_sda_oe_in
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);
  ////////////////////////////////////////////////////////////////////////////
  dev_stable_a: assert property ($changed(dev_sda_oe_in) |-> !scl_in)
    else $error("device data moved with clock high");
  dev_hold_a: assert property ($changed(dev_sda_oe_in) |-> !$past(scl_in, 3))
    else $error("device data moved too soon after clock fall");
  dev_setup_a: assert property ($changed(dev_sda_oe_in) |-> (!scl_in) [*4])
    else $error("device data moved too close to clock rise");
  start_hold_a: assert property ($fell(sda_in) && scl_in |-> scl_in [*8])
    else $error("start not held with clock high");
  stop_idle_a: assert property ($rose(sda_in) && scl_in |-> (scl_in && sda_in) [*8])
    else $error("lines not left high after stop");
  // both ends may pull low together while the clock is low at an ack hand-over
  no_fight_a: assert property (!(host_sda_oe_in && dev_sda_oe_in && scl_in))
    else $error("both ends pull data with clock high");
  clk_high_a: assert property ($rose(scl_in) |-> scl_in [*8])
    else $error("clock high phase too short");
  clk_low_a: assert property ($fell(scl_in) |-> (!scl_in) [*8])
    else $error("clock low phase too short");
endmodule
`default_nettype wire

// [dv/smbus_config_slave_test.sv]
// self-checking bench joining host and slave ends over the management link
`timescale 1ns/1ns
`default_nettype none
module smbus_config_slave_test;
  localparam int Q = 10;
  logic clk_sys_in = 1'h0;
  logic reset_n_in = 1'h0;
  logic req_in = 1'h0, rw_in = 1'h0, en = 1'h1;
  logic [6:0] dev_addr = 7'h50;
  logic [7:0] idx = 8'h00, wd = 8'h00, rdata, idle_det = 8'h00, rate_det = 8'h00;
  logic [3:0] gpio_in = 4'h0, gpio_out, gpio_oe;
  logic busy, done, nack, refused, swing_set, bus_idle;
  logic [3:0][7:0] eq;
  logic [7:0][7:0] swing, deemph;
  logic [11:0] note;
  logic [11:0] notes[$];
  int mismatches = 0;
  int samples_checked = 0;
  int cycles = 0;
  int seed;
  smbus_link_if link();
  smbus_cfg_host #(.QUARTER_CYC(Q)) i_smbus_cfg_host (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
    .bus(link), .req_in(req_in), .rw_in(rw_in), .dev_addr_in(dev_addr), .index_in(idx), .wdata_in(wd),
    .busy_out(busy), .done_out(done), .nack_out(nack), .refused_out(refused), .rdata_out(rdata),
    .swing_set_out(swing_set));
  smbus_cfg_slave #(.HIGH_MAX_CYC(200)) i_smbus_cfg_slave (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
    .bus(link), .smbus_mode_enable_in(en), .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe_out(gpio_oe),
    .idle_det_in(idle_det), .rate_det_in(rate_det), .eq_out(eq), .swing_out(swing), .deemph_out(deemph),
    .bus_idle_out(bus_idle));
  smbus_link_monitor i_smbus_link_monitor (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .scl_in(link.scl),
    .sda_in(link.sda), .host_sda_oe_in(link.host_sda_oe), .dev_sda_oe_in(link.dev_sda_oe));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 90000) begin
      mismatches++;
      test_done();
    end
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // note layout: check data, check nack, nack, refused, data
  task automatic xfer(input logic rd, input logic [6:0] a, input logic [7:0] i, input logic [7:0] d,
                      input logic [7:0] er, input logic en_nack, input logic en_ref);
    @(negedge clk_sys_in);
    rw_in = rd;
    dev_addr = a;
    idx = i;
    wd = d;
    req_in = 1'h1;
    notes.push_back({rd & ~en_nack, ~en_ref, en_nack, en_ref, er});
    @(negedge clk_sys_in);
    req_in = 1'h0;
    if (!en_ref) chk("busy", 8'h01, {7'h00, busy});
    while (done !== 1'h1) @(negedge clk_sys_in);
  endtask
  always @(negedge clk_sys_in) begin
    if (reset_n_in && done === 1'h1) begin
      if (notes.size() == 0) begin
        mismatches++;
        $display("BAD note queue expected entry seen none");
        note = 12'h000;
      end else begin
        note = notes.pop_front();
      end
      chk("refused", {7'h00, note[8]}, {7'h00, refused});
      if (note[10]) chk("nack", {7'h00, note[9]}, {7'h00, nack});
      if (note[11]) chk("rdata", note[7:0], rdata);
    end
  end
  function automatic logic [3:0] pair(input logic [7:0] d);
    return {d[5] | d[7], d[4] | d[6], d[1] | d[3], d[0] | d[2]};
  endfunction
  task automatic status(input logic rate);
    logic [7:0] d;
    repeat (3) begin
      d = 8'($random(seed));
      if (rate) rate_det = d;
      else idle_det = d;
      repeat (8) @(negedge clk_sys_in);
      chk("status pins", {4'h0, pair(d)}, {4'h0, gpio_out});
      chk("pin enables", 8'h0F, {4'h0, gpio_oe});
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'h450F;
    repeat (12) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    reset_n_in = 1'h1;
    repeat (5) @(negedge clk_sys_in);
    xfer(1'h1, 7'h50, 8'h0F, 8'h00, 8'h20, 1'h0, 1'h0);
    xfer(1'h1, 7'h51, 8'h0F, 8'h00, 8'h00, 1'h1, 1'h0);
    for (int k = 0; k < 4; k++) begin
      gpio_in = 4'h1 << k;
      repeat (5) @(negedge clk_sys_in);
      xfer(1'h1, {3'h5, gpio_in}, 8'h10, 8'h00, 8'h03, 1'h0, 1'h0);
    end
    gpio_in = 4'h0;
    $display("test addressing finished");
    for (int k = 0; k < 4; k++) begin
      xfer(1'h0, 7'h50, smbus_cfg_pkg::EQ_OFS[k], 8'h39, 8'h00, 1'h0, 1'h0);
      chk("eq", 8'h39, eq[k]);
    end
    xfer(1'h1, 7'h50, 8'h24, 8'h00, 8'h39, 1'h0, 1'h0);
    for (int k = 0; k < 8; k++) begin
      xfer(1'h0, 7'h50, smbus_cfg_pkg::DEEMPH_OFS[k], smbus_cfg_pkg::DEEMPH_CODES[k % 5], 8'h00, 1'h0, 1'h0);
      chk("deemph", smbus_cfg_pkg::DEEMPH_CODES[k % 5], deemph[k]);
    end
    xfer(1'h0, 7'h50, 8'h11, 8'h55, 8'h00, 1'h0, 1'h1);
    chk("deemph kept", 8'h01, deemph[0]);
    for (int k = 0; k < 8; k++) begin
      xfer(1'h0, 7'h50, smbus_cfg_pkg::SWING_OFS[k], 8'h0F, 8'h00, 1'h0, 1'h0);
    end
    chk("swing", 8'h0F, swing[7]);
    chk("swing set", 8'h01, {7'h00, swing_set});
    $display("test registers finished");
    xfer(1'h0, 7'h50, 8'h00, 8'h01, 8'h00, 1'h0, 1'h0);
    chk("eq default", 8'h20, eq[3]);
    chk("swing default", 8'h03, swing[7]);
    chk("deemph default", 8'h00, deemph[7]);
    chk("swing cleared", 8'h00, {7'h00, swing_set});
    xfer(1'h1, 7'h50, 8'h00, 8'h00, 8'h00, 1'h0, 1'h0);
    $display("test soft reset finished");
    xfer(1'h0, 7'h50, 8'h4E, 8'h01, 8'h00, 1'h0, 1'h0);
    xfer(1'h0, 7'h50, 8'h47, 8'h32, 8'h00, 1'h0, 1'h0);
    status(1'h0);
    xfer(1'h0, 7'h50, 8'h47, 8'h00, 8'h00, 1'h0, 1'h0);
    xfer(1'h0, 7'h50, 8'h4C, 8'hC0, 8'h00, 1'h0, 1'h0);
    status(1'h1);
    $display("test status pins finished");
    repeat (500) @(negedge clk_sys_in);
    chk("bus idle", 8'h01, {7'h00, bus_idle});
    en = 1'h0;
    repeat (5) @(negedge clk_sys_in);
    xfer(1'h1, 7'h50, 8'h0F, 8'h00, 8'h00, 1'h1, 1'h0);
    chk("pin enables off", 8'h00, {4'h0, gpio_oe});
    en = 1'h1;
    $display("test enable finished");
    test_done();
  end
endmodule
`default_nettype wire
